/* uart_remote.sv */
// remote serial device: 8n1 sender and receiver on plain and infrared lines
`timescale 1ns/1ps
module uart_remote #(
	parameter int BIT = 16
) (
	input	wire logic	pclk,
	input	wire logic	sout,
	input	wire logic	sir_out_n,
	output	logic		sin,
	output	logic		sir_in
);
	logic [7:0] got[$];
	initial begin
		sin = 1'b1;
		sir_in = 1'b0;
	end
	// an infrared zero is a high pulse over the first 3 of 16 ticks of a bit
	task automatic send(input logic ir, input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			sin <= ir | f[i];
			sir_in <= ir & !f[i];
			repeat (3 * BIT / 16) @(posedge pclk);
			sir_in <= 1'b0;
			repeat (BIT - 3 * BIT / 16) @(posedge pclk);
		end
	endtask
	// plain line sampled mid-bit; bad stop bit drops the character
	always begin : plain_rx
		logic [7:0] d;
		@(negedge sout);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge pclk);
			d[i] = sout;
		end
		repeat (BIT) @(posedge pclk);
		if (sout === 1'b1)
			got.push_back(d);
	end
	always begin : ir_rx
		logic [7:0] d;
		@(negedge sir_out_n);
		repeat (BIT) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			d[i] = 1'b1;
			repeat (BIT) begin
				@(posedge pclk);
				if (sir_out_n === 1'b0)
					d[i] = 1'b0;
			end
		end
		got.push_back(d);
	end
endmodule

/* uart_shadow_chk.sv */
// pin-level assertions for the shadow data port
`timescale 1ns/1ps
module uart_shadow_chk
	import uart_shadow_pkg::*;
#(
	parameter int TICK_DIVIDE = uart_shadow_pkg::TICK_DIV
) (
	input	wire logic		pclk,
	input	wire logic		presetn,
	input	wire logic		psel,
	input	wire logic		penable,
	input	wire logic		pwrite,
	input	wire logic [31:0]	paddr,
	input	wire logic [31:0]	pwdata,
	input	wire logic [31:0]	prdata,
	input	wire logic		pready,
	input	wire logic		pslverr,
	input	wire logic		sin,
	input	wire logic		sir_in,
	input	wire logic		sout,
	input	wire logic		sir_out_n
);
	logic		acc;
	logic		shadow;
	logic		mapped;
	logic		ir_ff;
	logic		nxt_ir;
	logic [15:0]	lo_ff;
	logic [15:0]	nxt_lo;
	assign acc = psel && penable;
	assign shadow = paddr >= SHADOW_BASE_ADDR && paddr <= SHADOW_LAST_ADDR;
	assign mapped = shadow || paddr == FIFO_CONTROL_ADDR || paddr == MODE_CONTROL_ADDR ||
		paddr == LINE_STATUS_ADDR;
	// mode is tracked from bus writes so pin checks need no internal state
	always_comb begin
		nxt_ir = (acc && pwrite && paddr == MODE_CONTROL_ADDR) ? pwdata[IR_MODE_BIT] : ir_ff;
		nxt_lo = sir_out_n ? 16'h0000 : lo_ff + 16'h0001;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_ff <= 1'b0;
			lo_ff <= 16'h0000;
		end else begin
			ir_ff <= nxt_ir;
			lo_ff <= nxt_lo;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("no pready");
	property p_upper; acc && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_alias; acc && shadow && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
	a_alias: assert property (p_alias) else $error("slot refused");
	property p_unmap; acc && !mapped && paddr[1:0] == 2'b00 |-> pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped accepted");
	property p_errgate; pslverr |-> acc; endproperty
	a_errgate: assert property (p_errgate) else $error("stray pslverr");
	property p_irq; ir_ff && $past(ir_ff) |-> sout; endproperty
	a_irq: assert property (p_irq) else $error("sout moved in ir mode");
	property p_plq; !ir_ff && !$past(ir_ff) |-> sir_out_n; endproperty
	a_plq: assert property (p_plq) else $error("ir pulse in plain mode");
	property p_pulse; $rose(sir_out_n) |-> lo_ff == 3 * TICK_DIVIDE; endproperty
	a_pulse: assert property (p_pulse) else $error("ir pulse length");
	property p_rst; !$past(presetn) |-> sout && sir_out_n && prdata == WORD_ZERO; endproperty
	a_rst: assert property (p_rst) else $error("reset values");
	c_unmap: cover property (acc && !mapped && paddr[1:0] == 2'b00);
	c_pulse: cover property ($rose(sir_out_n) && ir_ff);
	c_wr: cover property (acc && pwrite && shadow);
endmodule
bind uart_shadow_data_port uart_shadow_chk #(.TICK_DIVIDE(TICK_DIVIDE)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sin(sin), .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n));

/* uart_shadow_data_port.sv */
// shadow receive/transmit data port of the serial block, apb slave and line engines
`timescale 1ns/1ps
module uart_shadow_data_port
	import uart_shadow_pkg::*;
#(
	parameter int TX_FIFO_DEPTH = uart_shadow_pkg::TX_DEPTH,
	parameter int RX_FIFO_DEPTH = uart_shadow_pkg::RX_DEPTH,
	parameter int TICK_DIVIDE   = uart_shadow_pkg::TICK_DIV
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sin,
	input  wire logic        sir_in,
	output logic             sout,
	output logic             sir_out_n
);
	import uart_shadow_pkg::*;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic is_shadow(input logic [31:0] a);
		is_shadow = (a >= SHADOW_BASE_ADDR) && (a <= SHADOW_LAST_ADDR) && (a[1:0] == 2'b00);
	endfunction

	logic setup;
	logic access;
	logic wr_done;
	logic rd_done;
	logic hit_shadow;
	assign setup      = psel & ~penable;
	assign access     = psel & penable;
	assign wr_done    = access & pwrite;
	assign rd_done    = access & ~pwrite;
	assign hit_shadow = is_shadow(paddr);
	assign pready     = access;

	// ----------------------------------------------------------------
	// control and receive/transmit holding state
	// ----------------------------------------------------------------
	ctrl_t      ctrl_ff;
	ctrl_t      nxt_ctrl;
	char_hold_t rxh_ff;
	char_hold_t nxt_rxh;
	char_hold_t txh_ff;
	char_hold_t nxt_txh;
	logic       overrun_ff;
	logic       nxt_overrun;
	logic       flush;

	logic       txf_out_valid;
	logic       txf_out_ready;
	logic [7:0] txf_out_data;
	logic       rxf_in_valid;
	logic       rxf_in_ready;
	logic       rxf_out_valid;
	logic       rxf_out_ready;
	logic [7:0] rxf_out_data;

	logic       rx_done;
	logic [7:0] rx_char;
	logic       tx_take;
	logic       tx_idle;
	logic       pop_ok_ff;
	logic       nxt_pop_ok;
	logic       sts_rd_ff;
	logic       nxt_sts_rd;

	logic       data_ready;
	logic       txh_empty;
	logic       shadow_wr;
	logic       shadow_rd;
	logic [7:0] rx_head;

	assign data_ready = ctrl_ff.fifo_en ? rxf_out_valid : rxh_ff.pending;
	assign txh_empty  = ctrl_ff.fifo_en ? ~txf_out_valid : ~txh_ff.pending;
	assign rx_head    = ctrl_ff.fifo_en ? rxf_out_data : rxh_ff.data;
	assign shadow_wr  = wr_done & hit_shadow;
	assign shadow_rd  = rd_done & hit_shadow & pop_ok_ff;
	// switching fifo mode discards whatever was buffered in either direction
	assign flush      = wr_done && (paddr == FIFO_CONTROL_ADDR) &&
		(pwdata[FIFO_EN_BIT] != ctrl_ff.fifo_en);

	assign rxf_in_valid  = rx_done & ctrl_ff.fifo_en;
	assign rxf_out_ready = shadow_rd & ctrl_ff.fifo_en;
	assign txf_out_ready = tx_take & ctrl_ff.fifo_en;

	always_comb begin
		nxt_ctrl    = ctrl_ff;
		nxt_rxh     = rxh_ff;
		nxt_txh     = txh_ff;
		nxt_overrun = overrun_ff;
		if (wr_done && paddr == FIFO_CONTROL_ADDR) begin
			nxt_ctrl.fifo_en = pwdata[FIFO_EN_BIT];
		end
		if (wr_done && paddr == MODE_CONTROL_ADDR) begin
			nxt_ctrl.ir_mode = pwdata[IR_MODE_BIT];
		end
		// single receive holding byte
		if (shadow_rd && !ctrl_ff.fifo_en) begin
			nxt_rxh.pending = 1'b0;
		end
		if (rx_done && !ctrl_ff.fifo_en) begin
			nxt_rxh.data    = rx_char;
			nxt_rxh.pending = 1'b1;
		end
		if (flush) begin
			nxt_rxh.pending = 1'b0;
			nxt_txh.pending = 1'b0;
		end
		// single transmit holding byte; a write in the take cycle stays pending
		if (tx_take && !ctrl_ff.fifo_en) begin
			nxt_txh.pending = 1'b0;
		end
		if (shadow_wr && !ctrl_ff.fifo_en) begin
			nxt_txh.data    = pwdata[DATA_MSB:0];
			nxt_txh.pending = 1'b1;
		end
		// overrun is sticky, cleared by reading line status; a new event wins
		if (sts_rd_ff && rd_done && paddr == LINE_STATUS_ADDR) begin
			nxt_overrun = 1'b0;
		end
		if (rx_done && !ctrl_ff.fifo_en && rxh_ff.pending && !shadow_rd) begin
			nxt_overrun = 1'b1;
		end
		if (rxf_in_valid && !rxf_in_ready) begin
			nxt_overrun = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff    <= '0;
			rxh_ff     <= '{pending: 1'b0, data: DATA_RESET};
			txh_ff     <= '{pending: 1'b0, data: DATA_RESET};
			overrun_ff <= 1'b0;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			rxh_ff     <= nxt_rxh;
			txh_ff     <= nxt_txh;
			overrun_ff <= nxt_overrun;
		end
	end

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------
	// a full transmit fifo refuses the write, so the character is lost
	uart_shadow_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.flush     (flush),
		.in_valid  (shadow_wr & ctrl_ff.fifo_en),
		.in_ready  (),
		.in_data   (pwdata[DATA_MSB:0]),
		.out_valid (txf_out_valid),
		.out_ready (txf_out_ready),
		.out_data  (txf_out_data)
	);

	uart_shadow_fifo #(.WIDTH(8), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.flush     (flush),
		.in_valid  (rxf_in_valid),
		.in_ready  (rxf_in_ready),
		.in_data   (rx_char),
		.out_valid (rxf_out_valid),
		.out_ready (rxf_out_ready),
		.out_data  (rxf_out_data)
	);

	// ----------------------------------------------------------------
	// apb read data, captured in the setup cycle
	// ----------------------------------------------------------------
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        pslverr_ff;
	logic        nxt_pslverr;

	always_comb begin
		nxt_prdata  = prdata_ff;
		nxt_pslverr = pslverr_ff;
		nxt_pop_ok  = pop_ok_ff;
		nxt_sts_rd  = sts_rd_ff;
		if (setup) begin
			nxt_prdata  = WORD_ZERO;
			nxt_pslverr = 1'b0;
			// pop only what was seen, so a char landing mid-transfer is not lost
			nxt_pop_ok  = data_ready;
			nxt_sts_rd  = (paddr == LINE_STATUS_ADDR);
			if (hit_shadow) begin
				nxt_prdata[DATA_MSB:0] = rx_head;
			end else if (paddr == FIFO_CONTROL_ADDR) begin
				nxt_prdata[FIFO_EN_BIT] = ctrl_ff.fifo_en;
			end else if (paddr == MODE_CONTROL_ADDR) begin
				nxt_prdata[IR_MODE_BIT] = ctrl_ff.ir_mode;
			end else if (paddr == LINE_STATUS_ADDR) begin
				nxt_prdata[STS_DATA_READY_BIT] = data_ready;
				nxt_prdata[STS_OVERRUN_BIT]    = overrun_ff;
				nxt_prdata[STS_TXH_EMPTY_BIT]  = txh_empty;
				nxt_prdata[STS_TX_IDLE_BIT]    = txh_empty & tx_idle;
			end else begin
				nxt_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= WORD_ZERO;
			pslverr_ff <= 1'b0;
			pop_ok_ff  <= 1'b0;
			sts_rd_ff  <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
			pop_ok_ff  <= nxt_pop_ok;
			sts_rd_ff  <= nxt_sts_rd;
		end
	end

	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff & access;

	// ----------------------------------------------------------------
	// oversample tick divider
	// ----------------------------------------------------------------
	logic [15:0] div_ff;
	logic [15:0] nxt_div;
	logic        tick;
	assign tick = (div_ff == 16'(TICK_DIVIDE - 1));

	always_comb begin
		nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 16'h0000;
		end else begin
			div_ff <= nxt_div;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	line_state_t tx_state_ff;
	line_state_t nxt_tx_state;
	logic [7:0]  tx_shift_ff;
	logic [7:0]  nxt_tx_shift;
	logic [2:0]  tx_bit_ff;
	logic [2:0]  nxt_tx_bit;
	logic [3:0]  tx_cnt_ff;
	logic [3:0]  nxt_tx_cnt;
	logic        sout_ff;
	logic        nxt_sout;
	logic        sir_ff;
	logic        nxt_sir;
	logic        tx_line;
	logic        tx_src_valid;

	assign tx_src_valid = ctrl_ff.fifo_en ? txf_out_valid : txh_ff.pending;
	assign tx_take      = tick & (tx_state_ff == LINE_IDLE) & tx_src_valid;
	assign tx_idle      = (tx_state_ff == LINE_IDLE);

	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_shift = tx_shift_ff;
		nxt_tx_bit   = tx_bit_ff;
		nxt_tx_cnt   = tx_cnt_ff;
		tx_line      = 1'b1;
		case (tx_state_ff)
			LINE_IDLE: begin
				if (tx_take) begin
					nxt_tx_shift = ctrl_ff.fifo_en ? txf_out_data : txh_ff.data;
					nxt_tx_cnt   = 4'h0;
					nxt_tx_state = LINE_START;
				end
			end
			LINE_START: begin
				tx_line = 1'b0;
			end
			LINE_DATA: begin
				tx_line = tx_shift_ff[0];
			end
			LINE_STOP: begin
				tx_line = 1'b1;
			end
			default: begin
				nxt_tx_state = LINE_IDLE;
			end
		endcase
		if (tick && tx_state_ff != LINE_IDLE) begin
			nxt_tx_cnt = tx_cnt_ff + 4'h1;
			if (tx_cnt_ff == TICK_LAST) begin
				case (tx_state_ff)
					LINE_START: begin
						nxt_tx_bit   = 3'h0;
						nxt_tx_state = LINE_DATA;
					end
					LINE_DATA: begin
						nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
						nxt_tx_bit   = tx_bit_ff + 3'h1;
						if (tx_bit_ff == BIT_LAST) begin
							nxt_tx_state = LINE_STOP;
						end
					end
					default: begin
						nxt_tx_state = LINE_IDLE;
					end
				endcase
			end
		end
		// infrared: a zero bit is a short low pulse, everything else idles high
		nxt_sout = ctrl_ff.ir_mode ? 1'b1 : tx_line;
		nxt_sir  = ~(ctrl_ff.ir_mode && !tx_line && tx_cnt_ff < IR_PULSE_TICKS);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_ff <= LINE_IDLE;
			tx_shift_ff <= 8'h00;
			tx_bit_ff   <= 3'h0;
			tx_cnt_ff   <= 4'h0;
			sout_ff     <= 1'b1;
			sir_ff      <= 1'b1;
		end else begin
			tx_state_ff <= nxt_tx_state;
			tx_shift_ff <= nxt_tx_shift;
			tx_bit_ff   <= nxt_tx_bit;
			tx_cnt_ff   <= nxt_tx_cnt;
			sout_ff     <= nxt_sout;
			sir_ff      <= nxt_sir;
		end
	end

	assign sout      = sout_ff;
	assign sir_out_n = sir_ff;

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	line_state_t rx_state_ff;
	line_state_t nxt_rx_state;
	logic [7:0]  rx_shift_ff;
	logic [7:0]  nxt_rx_shift;
	logic [2:0]  rx_bit_ff;
	logic [2:0]  nxt_rx_bit;
	logic [3:0]  rx_cnt_ff;
	logic [3:0]  nxt_rx_cnt;
	logic [3:0]  ir_hold_ff;
	logic [3:0]  nxt_ir_hold;
	logic        rx_line;

	// an infrared pulse is stretched over one bit time so mid-bit sampling sees it
	assign rx_line = ctrl_ff.ir_mode ? (ir_hold_ff == 4'h0) : sin;
	assign rx_done = tick & (rx_state_ff == LINE_STOP) & (rx_cnt_ff == TICK_LAST) & rx_line;
	assign rx_char = rx_shift_ff;

	always_comb begin
		nxt_rx_state = rx_state_ff;
		nxt_rx_shift = rx_shift_ff;
		nxt_rx_bit   = rx_bit_ff;
		nxt_rx_cnt   = rx_cnt_ff;
		nxt_ir_hold  = ir_hold_ff;
		if (sir_in) begin
			nxt_ir_hold = IR_STRETCH_TICKS;
		end else if (tick && ir_hold_ff != 4'h0) begin
			nxt_ir_hold = ir_hold_ff - 4'h1;
		end
		if (tick) begin
			nxt_rx_cnt = rx_cnt_ff + 4'h1;
			case (rx_state_ff)
				LINE_IDLE: begin
					nxt_rx_cnt = 4'h0;
					if (!rx_line) begin
						nxt_rx_state = LINE_START;
					end
				end
				LINE_START: begin
					if (rx_cnt_ff == TICK_MID) begin
						nxt_rx_cnt   = 4'h0;
						nxt_rx_bit   = 3'h0;
						nxt_rx_state = rx_line ? LINE_IDLE : LINE_DATA;
					end
				end
				LINE_DATA: begin
					if (rx_cnt_ff == TICK_LAST) begin
						nxt_rx_shift = {rx_line, rx_shift_ff[7:1]};
						nxt_rx_bit   = rx_bit_ff + 3'h1;
						if (rx_bit_ff == BIT_LAST) begin
							nxt_rx_state = LINE_STOP;
						end
					end
				end
				LINE_STOP: begin
					if (rx_cnt_ff == TICK_LAST) begin
						nxt_rx_state = LINE_IDLE;
					end
				end
				default: begin
					nxt_rx_state = LINE_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_ff <= LINE_IDLE;
			rx_shift_ff <= 8'h00;
			rx_bit_ff   <= 3'h0;
			rx_cnt_ff   <= 4'h0;
			ir_hold_ff  <= 4'h0;
		end else begin
			rx_state_ff <= nxt_rx_state;
			rx_shift_ff <= nxt_rx_shift;
			rx_bit_ff   <= nxt_rx_bit;
			rx_cnt_ff   <= nxt_rx_cnt;
			ir_hold_ff  <= nxt_ir_hold;
		end
	end
endmodule

/* uart_shadow_data_port_tb.sv */
// self-checking testbench for the shadow data port
`timescale 1ns/1ps
`define chk(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: got %h want %h", $time, a, e); end end
module uart_shadow_data_port_tb;
	import uart_shadow_pkg::*;
	logic		pclk = 1'b0;
	logic		presetn = 1'b0;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [31:0]	paddr = WORD_ZERO;
	logic [31:0]	pwdata = WORD_ZERO;
	logic [31:0]	prdata;
	logic		pready;
	logic		pslverr;
	logic		sin;
	logic		sir_in;
	logic		sout;
	logic		sir_out_n;
	logic [31:0]	rd;
	logic		err;
	int		n_fail = 0;
	int		n_checks = 0;
	always #50 pclk = ~pclk;
	uart_shadow_data_port #(.TICK_DIVIDE(1)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sin(sin), .sir_in(sir_in),
		.sout(sout), .sir_out_n(sir_out_n));
	uart_remote #(.BIT(16)) far (.pclk(pclk), .sout(sout), .sir_out_n(sir_out_n),
		.sin(sin), .sir_in(sir_in));
	// one idle cycle after each transfer keeps psel from being driven twice in a step
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_sts(input int b);
		int k;
		k = 0;
		do begin
			apb(1'b0, LINE_STATUS_ADDR, WORD_ZERO);
			k++;
		end while (rd[b] !== 1'b1 && k < 3000);
		`chk(rd[b], 1'b1)
	endtask
	task automatic t_map();
		apb(1'b0, SHADOW_SLOT6_ADDR, WORD_ZERO);
		`chk(rd, WORD_ZERO)
		apb(1'b0, SHADOW_LAST_ADDR, WORD_ZERO);
		`chk(err, 1'b0)
		apb(1'b1, 32'h5000_1080, 32'h0000_00ff);
		`chk(err, 1'b1)
		$display("map test done");
	endtask
	task automatic t_rx_plain();
		far.send(1'b0, 8'ha5);
		wait_sts(STS_DATA_READY_BIT);
		apb(1'b0, SHADOW_BASE_ADDR + 32'h0000_000c, WORD_ZERO);
		`chk(rd, 32'h0000_00a5)
		far.send(1'b0, 8'h5a);
		far.send(1'b0, 8'hc3);
		wait_sts(STS_OVERRUN_BIT);
		apb(1'b0, SHADOW_SLOT6_ADDR, WORD_ZERO);
		`chk(rd[7:0], 8'hc3)
		apb(1'b0, LINE_STATUS_ADDR, WORD_ZERO);
		`chk(rd[1:0], 2'b00)
		$display("plain receive test done");
	endtask
	task automatic t_tx_plain();
		far.got.delete();
		apb(1'b1, SHADOW_BASE_ADDR, 32'h0000_ff3c);
		apb(1'b1, SHADOW_SLOT6_ADDR, 32'h0000_0011);
		apb(1'b0, LINE_STATUS_ADDR, WORD_ZERO);
		`chk(rd[STS_TXH_EMPTY_BIT], 1'b0)
		apb(1'b1, SHADOW_LAST_ADDR, 32'h0000_0022);
		wait_sts(STS_TX_IDLE_BIT);
		`chk(far.got.size(), 2)
		`chk(far.got[0], 8'h3c)
		`chk(far.got[1], 8'h22)
		$display("plain transmit test done");
	endtask
	task automatic t_fifo();
		far.got.delete();
		apb(1'b1, FIFO_CONTROL_ADDR, 32'h0000_0001);
		for (int i = 0; i <= RX_DEPTH; i++)
			far.send(1'b0, 8'h40 + i[7:0]);
		wait_sts(STS_OVERRUN_BIT);
		for (int i = 0; i < RX_DEPTH; i++) begin
			apb(1'b0, SHADOW_BASE_ADDR + 32'(4 * i), WORD_ZERO);
			`chk(rd[7:0], 8'h40 + i[7:0])
		end
		apb(1'b0, LINE_STATUS_ADDR, WORD_ZERO);
		`chk(rd[STS_DATA_READY_BIT], 1'b0)
		wait_sts(STS_TXH_EMPTY_BIT);
		for (int i = 0; i < TX_DEPTH + 2; i++)
			apb(1'b1, SHADOW_SLOT6_ADDR, 32'h60 + 32'(i));
		wait_sts(STS_TX_IDLE_BIT);
		`chk(far.got.size(), TX_DEPTH + 1)
		for (int i = 0; i <= TX_DEPTH; i++)
			`chk(far.got[i], 8'h60 + i[7:0])
		$display("fifo test done");
	endtask
	task automatic t_ir();
		far.got.delete();
		apb(1'b1, FIFO_CONTROL_ADDR, WORD_ZERO);
		apb(1'b1, MODE_CONTROL_ADDR, 32'h0000_0001);
		far.send(1'b1, 8'h96);
		wait_sts(STS_DATA_READY_BIT);
		apb(1'b0, SHADOW_SLOT6_ADDR, WORD_ZERO);
		`chk(rd[7:0], 8'h96)
		wait_sts(STS_TXH_EMPTY_BIT);
		apb(1'b1, SHADOW_SLOT6_ADDR, 32'h0000_004d);
		wait_sts(STS_TX_IDLE_BIT);
		`chk(far.got.size(), 1)
		`chk(far.got[0], 8'h4d)
		apb(1'b1, MODE_CONTROL_ADDR, WORD_ZERO);
		$display("infrared test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_map();
		t_rx_plain();
		t_tx_plain();
		t_fifo();
		t_ir();
		tally_and_finish();
	end
	// the whole run needs about 5500 cycles
	initial begin
		repeat (40000) @(posedge pclk);
		n_fail++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule

/* uart_shadow_fifo.sv */
// synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module uart_shadow_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    nxt_wr_ptr;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW-1:0]    nxt_rd_ptr;
	logic [AW:0]      count_ff;
	logic [AW:0]      nxt_count;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data  = mem_ff[rd_ptr_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		nxt_mem    = mem_ff;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count  = count_ff;
		if (flush) begin
			nxt_wr_ptr = '0;
			nxt_rd_ptr = '0;
			nxt_count  = '0;
		end else begin
			if (push) begin
				nxt_mem[wr_ptr_ff] = in_data;
				nxt_wr_ptr         = ptr_inc(wr_ptr_ff);
			end
			if (pop) begin
				nxt_rd_ptr = ptr_inc(rd_ptr_ff);
			end
			if (push && !pop) begin
				nxt_count = count_ff + 1'b1;
			end else if (pop && !push) begin
				nxt_count = count_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			mem_ff    <= nxt_mem;
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
		end
	end
endmodule

/* uart_shadow_pkg.sv */
// package: address map, field layout, reset values, timing counts and carrier types
package uart_shadow_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [31:0] SHADOW_BASE_ADDR   = 32'h5000_1030;
	localparam logic [31:0] SHADOW_SLOT6_ADDR  = 32'h5000_1048;
	localparam logic [31:0] SHADOW_LAST_ADDR   = 32'h5000_106c;
	localparam logic [31:0] FIFO_CONTROL_ADDR  = 32'h5000_1070;
	localparam logic [31:0] MODE_CONTROL_ADDR  = 32'h5000_1074;
	localparam logic [31:0] LINE_STATUS_ADDR   = 32'h5000_1078;

	// ----------------------------------------------------------------
	// fields
	// ----------------------------------------------------------------
	localparam int          DATA_MSB           = 7;
	localparam int          FIFO_EN_BIT        = 0;
	localparam int          IR_MODE_BIT        = 0;
	localparam int          STS_DATA_READY_BIT = 0;
	localparam int          STS_OVERRUN_BIT    = 1;
	localparam int          STS_TXH_EMPTY_BIT  = 5;
	localparam int          STS_TX_IDLE_BIT    = 6;
	localparam logic [7:0]  DATA_RESET         = 8'h00;
	localparam logic [31:0] WORD_ZERO          = 32'h0000_0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ             = 10_000_000;
	localparam int          BAUD_HZ            = 115_200;
	localparam int          OVERSAMPLE         = 16;
	localparam int          TICK_DIV           = (CLK_HZ / (BAUD_HZ * OVERSAMPLE) < 1) ? 1 :
		CLK_HZ / (BAUD_HZ * OVERSAMPLE);
	localparam logic [3:0]  TICK_LAST          = 4'hf;
	localparam logic [3:0]  TICK_MID           = 4'h7;
	localparam logic [3:0]  IR_PULSE_TICKS     = 4'h3;
	localparam logic [3:0]  IR_STRETCH_TICKS   = 4'hf;
	localparam logic [2:0]  BIT_LAST           = 3'h7;
	localparam int          TX_DEPTH           = 16;
	localparam int          RX_DEPTH           = 8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		LINE_IDLE  = 4'b0001,
		LINE_START = 4'b0010,
		LINE_DATA  = 4'b0100,
		LINE_STOP  = 4'b1000
	} line_state_t;

	typedef struct packed {
		logic ir_mode;
		logic fifo_en;
	} ctrl_t;

	typedef struct packed {
		logic       pending;
		logic [7:0] data;
	} char_hold_t;

endpackage
